// file: cgs_pkg.sv
// Shared constants, types and register map of the strap and stop control block
package cgs_pkg;

    // Strap window length and the core clock rate
    localparam int STRAP_TIME_MS    = 2;                     // Three-state window after supply good
    localparam int CORE_CLK_KHZ     = 40000;                 // 40 MHz core clock
    localparam int STRAP_CYCLES_DEF = STRAP_TIME_MS * CORE_CLK_KHZ; // Window in core cycles
    localparam int TMR_W            = 17;                    // Timer width, holds the default

    // Clock-stop latency in CPU clock edges before the gate may move
    localparam logic [1:0] STOP_EDGES = 2'h2;

    // Register offsets and widths
    localparam int         ADDR_W     = 4;
    localparam int         DATA_W     = 8;
    localparam logic [3:0] REG_CFG    = 4'h0;                // Spread control, read/write
    localparam logic [3:0] REG_STATUS = 4'h1;                // Straps and gate state, read only

    // Field positions
    localparam int CFG_SS_LSB  = 0;                          // Spread bits 1-0
    localparam int ST_RUN_BIT  = 5;                          // Clock outputs enabled
    localparam int ST_GATE_BIT = 6;                          // Clock-stop gate open
    localparam int ST_PCI_BIT  = 7;                          // PCI gate open

    // Reset values
    localparam logic [1:0] CFG_SS_RST  = 2'h0;               // Spread off after power-up
    localparam logic [7:0] RDATA_RST   = 8'h00;

    // Strap pin indices
    localparam int PIN_SEL0 = 0;                             // 48 MHz output
    localparam int PIN_SEL1 = 1;                             // 24 MHz output
    localparam int PIN_SEL2 = 2;                             // Second reference output
    localparam int PIN_SEL3 = 3;                             // First gated PCI output
    localparam int PIN_MODE = 4;                             // Free-running PCI output
    localparam int NPIN     = 5;

    // Indices into the synchronised input vector
    localparam int SY_CPU  = 0;
    localparam int SY_PCI  = 1;
    localparam int SY_MEM  = 2;
    localparam int SY_REF  = 3;
    localparam int SY_C48  = 4;
    localparam int SY_C24  = 5;
    localparam int SY_STOP = 6;
    localparam int SY_VDD  = 7;
    localparam int SY_PIN2 = 8;
    localparam int SY_STRP = 9;
    localparam int NSYNC   = 14;

    // Power-up phases
    typedef enum logic [1:0] {
        CGS_WAIT_VDD = 2'b00,
        CGS_STRAP    = 2'b01,
        CGS_RUN      = 2'b10
    } cgs_phase_type;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } cgs_regbus_type;

    // Clock sources entering from the analogue side
    typedef struct packed {
        logic cpu;
        logic pci;
        logic mem;
        logic ref_clk;
        logic c48;
        logic c24;
    } cgs_src_type;

endpackage : cgs_pkg

// file: cgs_ctrl.sv
// Strap latch, PCI stop and clock-stop gating for the timing generator
//
// Functional notes
// - PCI stop low holds PCI 1-5 at 0
// - PCI stop sampled at PCI rise, applied next
// - Shared pin function follows latched mode strap
// - Memory clock copied to thirteen outputs
// - Clock-stop low silences twelve gated memory copies
// - Free-running memory copy ignores clock-stop
// - Straps read as inputs, latched, then outputs
// - Strap pins three-stated for first 2 ms
// - Window timer starts at supply good
// - Latched straps kept until power cycle
// - Window end enables outputs at strap frequency
// - Short first CPU cycle at enable accepted
// - Low strap latches 0, high latches 1
// - Config bits 1-0 switch spread spectrum
// - Spread applies only to CPU and PCI
// - Reference output follows crystal frequency
// - Clock-stop acts after full cycle, 2-3 clocks
// - Frequency straps latched, drive CPU/PCI frequency
`timescale 1ns/100ps

module cgs_ctrl
    import cgs_pkg::*;
#(
    parameter int STRAP_CYCLES = cgs_pkg::STRAP_CYCLES_DEF  // Shorten for simulation
) (
    // Clock, reset, enable
    input  wire logic                          core_clk_in,
    input  wire logic                          reset_in,
    input  wire logic                          ce_in,
    // Supply detector and stop inputs from the chipset
    input  wire logic                          vdd_ok_in,
    input  wire logic                          clk_stop_n_in,
    // Clock sources
    input  wire cgs_pkg::cgs_src_type          src_in,
    // Register port
    input  wire cgs_pkg::cgs_regbus_type       reg_in,
    output logic [cgs_pkg::DATA_W-1:0]         rdata_out,
    // Dual-purpose strap pins
    input  wire logic [cgs_pkg::NPIN-1:0]      strap_pin_in,
    output logic [cgs_pkg::NPIN-1:0]           strap_pin_out,
    output logic [cgs_pkg::NPIN-1:0]           strap_pin_oe_n_out,
    // Shared reference / PCI stop pin
    input  wire logic                          pin2_in,
    output logic                               pin2_out,
    output logic                               pin2_oe_n_out,
    // Clock outputs
    output logic                               cpu_free_clk_out,
    output logic                               cpu_gated_clk_out,
    output logic [3:0]                         pci_gated_clks_out,
    output logic                               ioapic_clk_out,
    output logic [11:0]                        mem_clk_gated_copies_out,
    output logic                               mem_clk_free_out,
    // Settings handed to the synthesiser
    output logic [3:0]                         freq_select_straps_out,
    output logic                               ss_cpu_pci_en_out
);
    import cgs_pkg::*;

    // All state of the block
    typedef struct packed {
        logic [NSYNC-1:0] s1;         // Synchroniser first stage
        logic [NSYNC-1:0] s2;         // Second stage
        logic [NSYNC-1:0] s3;         // Third stage
        logic [NSYNC-1:0] flt;        // Accepted level once stages two and three agree
        cgs_phase_type    phase;      // Power-up phase
        logic [TMR_W-1:0] timer;      // Strap window counter
        logic [NPIN-1:0]  straps;     // Latched strap levels
        logic             pci_lat;    // PCI stop level caught at PCI rise
        logic             pci_run;    // PCI gate, one PCI cycle behind the latch
        logic             stop_gate;  // Clock-stop gate, 1 lets clocks through
        logic [1:0]       stop_cnt;   // CPU edges seen while a change waits
        logic [1:0]       cfg_ss;     // Spread control bits
        logic [DATA_W-1:0] rdata;     // Read data, valid one cycle
        logic             cpu_f;
        logic             cpu_g;
        logic [NPIN-1:0]  pin_o;
        logic [NPIN-1:0]  pin_oe_n;
        logic             p2_o;
        logic             p2_oe_n;
        logic [3:0]       pci_g;
        logic             ioapic;
        logic [11:0]      mem_g;
        logic             mem_f;
        logic             ss_en;
    } cgs_state_type;

    cgs_state_type st_q;              // Registered state
    cgs_state_type st_d;              // Next state

    // Rise detect on an accepted clock level, used for CPU and PCI clocks
    function automatic logic rise_of(input logic old_lvl, input logic new_lvl);
        rise_of = !old_lvl && new_lvl;
    endfunction

    // Raw asynchronous inputs in synchroniser order
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {strap_pin_in, pin2_in, vdd_ok_in, clk_stop_n_in,
                     src_in.c24, src_in.c48, src_in.ref_clk, src_in.mem,
                     src_in.pci, src_in.cpu};

    logic [NSYNC-1:0] flt_nx;         // Filtered levels for this cycle
    logic             pci_rise;       // Free-running PCI clock rose
    logic             cpu_rise;       // CPU clock rose
    logic             run;            // Outputs enabled in the next state

    // Three-stage filter: a level counts only once stages two and three agree.
    // Stage one may go metastable, so only stage two ever reads it; the
    // agreement test also rejects a one-cycle glitch on any pin, at the
    // cost of up to four core cycles of latency on every source.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_filt
            assign flt_nx[gi] = (st_q.s2[gi] == st_q.s3[gi]) ? st_q.s3[gi] : st_q.flt[gi];
        end
    endgenerate

    assign pci_rise = rise_of(st_q.flt[SY_PCI], flt_nx[SY_PCI]);
    assign cpu_rise = rise_of(st_q.flt[SY_CPU], flt_nx[SY_CPU]);

    // Next-state logic
    always_comb begin
        st_d     = st_q;
        st_d.s1  = raw_in;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.flt = flt_nx;

        // Power-up sequence
        case (st_q.phase)
            CGS_WAIT_VDD: begin
                // Timer held until the supply detector reports good
                st_d.timer = '0;
                if (st_q.flt[SY_VDD]) begin
                    st_d.phase = CGS_STRAP;
                end
            end
            CGS_STRAP: begin
                // Pins float while the straps settle the loaded traces
                if (st_q.timer == TMR_W'(STRAP_CYCLES - 1)) begin
                    st_d.straps = st_q.flt[SY_STRP +: NPIN];
                    st_d.phase  = CGS_RUN;
                end else begin
                    st_d.timer = st_q.timer + 1'b1;
                end
            end
            CGS_RUN: begin
                // Straps stay put; only a power cycle (reset) reloads them
                st_d.phase = CGS_RUN;
            end
            default: begin
                st_d.phase = CGS_WAIT_VDD;
            end
        endcase
        run = (st_d.phase == CGS_RUN);

        // PCI stop: caught at one PCI rise, applied at the next. The gate only
        // moves on a rise, so a stop never cuts a high phase short.
        if (pci_rise) begin
            // Reference mode leaves no stop input, so PCI runs
            st_d.pci_lat = st_q.straps[PIN_MODE] ? 1'b1 : st_q.flt[SY_PIN2];
            st_d.pci_run = st_q.pci_lat;
        end

        // Clock-stop: wait two CPU edges, then move only with CPU low
        // A request shorter than that latency is dropped by the compare
        if (st_q.flt[SY_STOP] == st_q.stop_gate) begin
            st_d.stop_cnt = 2'h0;
        end else if (st_q.stop_cnt == STOP_EDGES && !flt_nx[SY_CPU]) begin
            // A full cycle has completed, so no runt pulse reaches the load
            st_d.stop_gate = st_q.flt[SY_STOP];
            st_d.stop_cnt  = 2'h0;
        end else if (cpu_rise && st_q.stop_cnt != STOP_EDGES) begin
            st_d.stop_cnt = st_q.stop_cnt + 2'h1;
        end

        // Dual-purpose pins: three-stated until the window closes
        if (run) begin
            st_d.pin_oe_n = '0;
            st_d.pin_o[PIN_SEL0] = flt_nx[SY_C48];
            st_d.pin_o[PIN_SEL1] = flt_nx[SY_C24];
            st_d.pin_o[PIN_SEL2] = flt_nx[SY_REF];
            st_d.pin_o[PIN_SEL3] = flt_nx[SY_PCI] & st_d.pci_run;
            st_d.pin_o[PIN_MODE] = flt_nx[SY_PCI];
        end else begin
            st_d.pin_oe_n = '1;
            st_d.pin_o    = '0;
        end

        // Shared pin drives the reference only in mode 1
        st_d.p2_oe_n = !(run && st_d.straps[PIN_MODE]);
        st_d.p2_o    = run && st_d.straps[PIN_MODE] && flt_nx[SY_REF];

        // Clock outputs; the first CPU pulse may be short, it is not trimmed
        st_d.cpu_f  = run && flt_nx[SY_CPU];
        st_d.cpu_g  = run && st_d.stop_gate && flt_nx[SY_CPU];
        st_d.pci_g  = {4{run && st_d.pci_run && flt_nx[SY_PCI]}};
        st_d.ioapic = run && st_d.stop_gate && flt_nx[SY_REF];
        st_d.mem_g  = {12{run && st_d.stop_gate && flt_nx[SY_MEM]}};
        st_d.mem_f  = run && flt_nx[SY_MEM];

        // Register writes; status is read only
        if (reg_in.wr && reg_in.addr == REG_CFG) begin
            st_d.cfg_ss = reg_in.wdata[CFG_SS_LSB +: 2];
        end
        // Any nonzero code in bits 1-0 turns spread on for CPU and PCI only
        st_d.ss_en = (st_d.cfg_ss != 2'h0);

        // Register reads, data valid only in the following cycle
        // Reads have no side effects, so polling status is harmless
        st_d.rdata = RDATA_RST;
        if (reg_in.rd) begin
            case (reg_in.addr)
                REG_CFG: begin
                    st_d.rdata[CFG_SS_LSB +: 2] = st_q.cfg_ss;
                end
                REG_STATUS: begin
                    st_d.rdata[NPIN-1:0]   = st_q.straps;
                    st_d.rdata[ST_RUN_BIT]  = (st_q.phase == CGS_RUN);
                    st_d.rdata[ST_GATE_BIT] = st_q.stop_gate;
                    st_d.rdata[ST_PCI_BIT]  = st_q.pci_run;
                end
                default: begin
                    // Unmapped offsets read as zero
                    st_d.rdata = RDATA_RST;
                end
            endcase
        end
    end

    // State register; reset stands for a power cycle
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q           <= '0;
            st_q.phase     <= CGS_WAIT_VDD;
            st_q.pci_lat   <= 1'b1;
            st_q.pci_run   <= 1'b1;
            st_q.stop_gate <= 1'b1;
            st_q.flt[SY_STOP] <= 1'b1;
            // Whole stop chain starts at its released level, so no false
            // clock-stop request appears while the stages refill after reset
            st_q.s1[SY_STOP]  <= 1'b1;
            st_q.s2[SY_STOP]  <= 1'b1;
            st_q.s3[SY_STOP]  <= 1'b1;
            st_q.cfg_ss    <= CFG_SS_RST;
            st_q.pin_oe_n  <= '1;
            st_q.p2_oe_n   <= 1'b1;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign rdata_out                = st_q.rdata;
    assign strap_pin_out            = st_q.pin_o;
    assign strap_pin_oe_n_out       = st_q.pin_oe_n;
    assign pin2_out                 = st_q.p2_o;
    assign pin2_oe_n_out            = st_q.p2_oe_n;
    assign cpu_free_clk_out         = st_q.cpu_f;
    assign cpu_gated_clk_out        = st_q.cpu_g;
    assign pci_gated_clks_out       = st_q.pci_g;
    assign ioapic_clk_out           = st_q.ioapic;
    assign mem_clk_gated_copies_out = st_q.mem_g;
    assign mem_clk_free_out         = st_q.mem_f;
    assign freq_select_straps_out   = st_q.straps[PIN_SEL3:PIN_SEL0];
    assign ss_cpu_pci_en_out        = st_q.ss_en;

    // Checks on the block's own behaviour
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in || !ce_in);

    pci_stop_hold_a: assert property (
        !st_q.pci_run |-> (st_q.pci_g == 4'h0 && !st_q.pin_o[PIN_SEL3]))
        else $error("PCI output active while stopped");

    pci_edge_only_a: assert property (
        $changed(st_q.pci_run) |-> $past(pci_rise))
        else $error("PCI gate moved off a PCI rise");

    pin2_mode_a: assert property (
        (st_q.phase == CGS_RUN && $past(st_q.phase == CGS_RUN))
        |-> (st_q.p2_oe_n == !st_q.straps[PIN_MODE]))
        else $error("Shared pin direction disagrees with mode");

    mem_gate_off_a: assert property (
        !st_q.stop_gate |-> (st_q.mem_g == 12'h000 && !st_q.cpu_g && !st_q.ioapic))
        else $error("Gated clock active under clock-stop");

    mem_free_run_a: assert property (
        (st_q.phase == CGS_RUN && $past(st_q.phase == CGS_RUN))
        |-> (st_q.mem_f == st_q.flt[SY_MEM]))
        else $error("Free memory copy not following input");

    strap_float_a: assert property (
        (st_q.phase != CGS_RUN) |-> (st_q.pin_oe_n == '1 && st_q.p2_oe_n))
        else $error("Strap pin driven inside window");

    strap_hold_a: assert property (
        (st_q.phase == CGS_RUN && $past(st_q.phase == CGS_RUN)) |-> $stable(st_q.straps))
        else $error("Latched straps changed");

    strap_latch_a: assert property (
        (st_q.phase == CGS_RUN && $past(st_q.phase == CGS_STRAP))
        |-> (st_q.straps == $past(st_q.flt[SY_STRP +: NPIN])))
        else $error("Strap latched wrong level");

    window_len_a: assert property (
        (st_q.phase == CGS_RUN && $past(st_q.phase == CGS_STRAP))
        |-> ($past(st_q.timer) == TMR_W'(STRAP_CYCLES - 1)))
        else $error("Strap window wrong length");

    stop_latency_a: assert property (
        ($changed(st_q.stop_gate)) |-> (!st_q.flt[SY_CPU] && $past(st_q.stop_cnt) == STOP_EDGES))
        else $error("Clock-stop applied early or mid-cycle");

    spread_en_a: assert property (
        (reg_in.wr && reg_in.addr == REG_CFG) |=> (st_q.ss_en == ($past(reg_in.wdata[1:0]) != 2'h0)))
        else $error("Spread enable not following bits 1-0");

    mem_copy_a: assert property (
        st_q.stop_gate |-> (st_q.mem_g == {12{st_q.mem_f}}))
        else $error("Gated memory copies differ from free copy");

    pins_drive_a: assert property (
        (st_q.phase == CGS_RUN) |-> (st_q.pin_oe_n == '0))
        else $error("Strap pin not driving after window");

    out_quiet_a: assert property (
        (st_q.phase != CGS_RUN)
        |-> (!st_q.cpu_f && !st_q.mem_f && st_q.mem_g == 12'h000 && st_q.pci_g == 4'h0))
        else $error("Clock output active before window end");

    ref_follow_a: assert property (
        (st_q.phase == CGS_RUN && st_q.straps[PIN_MODE])
        |-> (st_q.p2_o == st_q.flt[SY_REF] && st_q.pin_o[PIN_SEL2] == st_q.flt[SY_REF]))
        else $error("Reference output not following source");

    pin2_input_a: assert property (
        (st_q.phase == CGS_RUN && !st_q.straps[PIN_MODE]) |-> (st_q.p2_oe_n && !st_q.p2_o))
        else $error("Shared pin driven in stop-input mode");

endmodule // cgs_ctrl

// file: cgs_board_model.sv
// Board and chipset model: clock sources, supply detector, stop inputs, strap resistors
`timescale 1ns/100ps

module cgs_board_model
    import cgs_pkg::*;
(
    // Clock and scenario controls from the bench
    input  wire logic                    core_clk_in,
    input  wire logic [cgs_pkg::NPIN-1:0] strap_lvl_in,
    input  wire logic                    vdd_req_in,
    input  wire logic                    clk_stop_req_n_in,
    input  wire logic                    pci_stop_req_n_in,
    // Pin drive coming from the device
    input  wire logic [cgs_pkg::NPIN-1:0] dev_strap_in,
    input  wire logic [cgs_pkg::NPIN-1:0] dev_strap_oe_n_in,
    input  wire logic                    dev_pin2_in,
    input  wire logic                    dev_pin2_oe_n_in,
    // Levels seen by the device
    output cgs_pkg::cgs_src_type         src_out,
    output logic                         vdd_ok_out,
    output logic                         clk_stop_n_out,
    output logic [cgs_pkg::NPIN-1:0]     strap_pin_out,
    output logic                         pin2_out
);
    logic [7:0] cnt_q = 8'h00;          // Divider behind the abstract source clocks
    logic       pci_stop_n_q = 1'b1;    // Chipset drive of the PCI stop line

    // Stops change only on a core edge and the bench holds them for many cycles
    always_ff @(posedge core_clk_in) begin
        cnt_q          <= cnt_q + 8'h01;
        vdd_ok_out     <= vdd_req_in;
        clk_stop_n_out <= clk_stop_req_n_in;
        pci_stop_n_q   <= pci_stop_req_n_in;
    end

    // Sources run at least four times slower than the core clock so sampling sees every level
    assign src_out = '{cpu: cnt_q[1], pci: cnt_q[3], mem: cnt_q[2],
                       ref_clk: cnt_q[4], c48: cnt_q[1], c24: cnt_q[2]};

    // A released strap pin is pulled to its resistor level, else shows the device drive
    assign strap_pin_out = (dev_strap_oe_n_in & strap_lvl_in) | (~dev_strap_oe_n_in & dev_strap_in);
    // Shared pin: device drive wins when enabled, otherwise the chipset's stop level
    assign pin2_out = dev_pin2_oe_n_in ? pci_stop_n_q : dev_pin2_in;
endmodule // cgs_board_model

// file: tb_top.sv
// Self-checking testbench for the strap latch and stop gating block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
    import cgs_pkg::*;
    logic              core_clk = 1'b0;   // 40 MHz core clock
    logic              rst = 1'b1;        // Stands for a power cycle
    logic              vdd_req = 1'b0;    // Supply detector request
    logic              stop_n = 1'b1;     // Clock-stop request
    logic              pci_stop_n = 1'b1; // PCI stop request
    logic [4:0]        strap_lvl = 5'h00; // Resistor levels
    cgs_regbus_type    reg_bus = '0;      // Register request
    logic [7:0]        rdata;             // Read data
    logic [4:0]        sp_in, sp_out, sp_oe_n;
    logic              p2_in, p2_out, p2_oe_n, vdd_ok, cs_n, cpu_f, cpu_g, ioapic, mfree, ss;
    logic [3:0]        pci_g, fsel;
    logic [11:0]       mgated;
    cgs_src_type       src;
    int                num_errors = 0;
    int                comparisons = 0;
    int                tog[7];            // Toggle counts of watched clocks
    int                hi_mg, hi_pci, hi_cpu, mis_mem, mis_io;
    logic              mon = 1'b0;        // Observation window open
    logic [6:0]        tv, tv_prev;

    always #12.5 core_clk = ~core_clk;

    cgs_ctrl #(.STRAP_CYCLES(20)) dut_u (.core_clk_in(core_clk), .reset_in(rst), .ce_in(1'b1),
        .vdd_ok_in(vdd_ok), .clk_stop_n_in(cs_n), .src_in(src), .reg_in(reg_bus),
        .rdata_out(rdata), .strap_pin_in(sp_in), .strap_pin_out(sp_out),
        .strap_pin_oe_n_out(sp_oe_n), .pin2_in(p2_in), .pin2_out(p2_out),
        .pin2_oe_n_out(p2_oe_n), .cpu_free_clk_out(cpu_f), .cpu_gated_clk_out(cpu_g),
        .pci_gated_clks_out(pci_g), .ioapic_clk_out(ioapic), .mem_clk_gated_copies_out(mgated),
        .mem_clk_free_out(mfree), .freq_select_straps_out(fsel), .ss_cpu_pci_en_out(ss));

    cgs_board_model model_u (.core_clk_in(core_clk), .strap_lvl_in(strap_lvl),
        .vdd_req_in(vdd_req), .clk_stop_req_n_in(stop_n), .pci_stop_req_n_in(pci_stop_n),
        .dev_strap_in(sp_out), .dev_strap_oe_n_in(sp_oe_n), .dev_pin2_in(p2_out),
        .dev_pin2_oe_n_in(p2_oe_n), .src_out(src), .vdd_ok_out(vdd_ok),
        .clk_stop_n_out(cs_n), .strap_pin_out(sp_in), .pin2_out(p2_in));

    // Watched clocks: free mem, free PCI, gated PCI, reference, 48M, free CPU, gated CPU
    assign tv = {cpu_g, cpu_f, sp_out[0], p2_out, pci_g[0], sp_out[4], mfree};
    always @(posedge core_clk) begin
        if (mon) begin
            for (int k = 0; k < 7; k++) tog[k] += (tv[k] !== tv_prev[k]);
            hi_mg   += (mgated !== 12'h000);
            hi_pci  += ((pci_g !== 4'h0) || (sp_out[3] !== 1'b0));
            hi_cpu  += ((cpu_g !== 1'b0) || (ioapic !== 1'b0));
            mis_io  += (ioapic !== p2_out);
            mis_mem += (mgated !== {12{mfree}});
        end
        tv_prev <= tv;
    end

    task automatic observe(input int n);
        @(negedge core_clk);
        foreach (tog[k]) tog[k] = 0;
        hi_mg = 0; hi_pci = 0; hi_cpu = 0; mis_mem = 0; mis_io = 0; mon = 1'b1;
        repeat (n) @(posedge core_clk);
        @(negedge core_clk) mon = 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk) reg_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) reg_bus <= '0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk) reg_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) reg_bus <= '0;
        #1 d = rdata;
    endtask

    // Power cycle with the given strap levels, then wait for the clocks to run
    task automatic power_up(input logic [4:0] s);
        logic [7:0] d;
        @(posedge core_clk);
        rst <= 1'b1; vdd_req <= 1'b0; strap_lvl <= s;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk) #1;
        `CHK(sp_oe_n, 5'h1F)
        `CHK(fsel, 4'h0)
        `CHK({ss, mgated, mfree, cpu_f}, 15'h0000)
        repeat (50) @(posedge core_clk);
        rd(REG_STATUS, d);
        `CHK(d[ST_RUN_BIT], 1'b0)
        @(posedge core_clk) vdd_req <= 1'b1;
        repeat (10) @(posedge core_clk) #1;
        `CHK(sp_oe_n, 5'h1F)
        for (int i = 0; i < 100 && d[ST_RUN_BIT] !== 1'b1; i++) rd(REG_STATUS, d);
        `CHK(d[ST_RUN_BIT], 1'b1)
        `CHK(d[4:0], s)
        repeat (4) @(posedge core_clk) #1;
        `CHK(sp_oe_n, 5'h00)
        `CHK(fsel, s[3:0])
        `CHK(p2_oe_n, ~s[PIN_MODE])
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        logic [7:0] d;
        // Mode strap high: shared pin becomes the reference output
        power_up(5'b10110);
        observe(64);
        `CHK(mis_mem, 0)
        `CHK(tog[0] > 0, 1'b1)
        `CHK(tog[3] > 0, 1'b1)
        `CHK(tog[4] > 0, 1'b1)
        `CHK(hi_pci > 0, 1'b1)
        `CHK(mis_io, 0)
        // Strap pins wiggling after the latch must not reach the latched bits
        @(posedge core_clk) strap_lvl <= 5'b01001;
        repeat (20) @(posedge core_clk);
        rd(REG_STATUS, d);
        `CHK(d[4:0], 5'b10110)
        // Every spread setting, back to back with read-back
        for (int v = 0; v < 4; v++) begin
            wr(REG_CFG, 8'(v));
            rd(REG_CFG, d);
            `CHK(d[1:0], 2'(v))
            `CHK(ss, 1'(v != 0))
        end
        wr(REG_STATUS, 8'h00);
        wr(4'hF, 8'hFF);
        rd(REG_STATUS, d);
        `CHK(d[4:0], 5'b10110)
        rd(4'hF, d);
        `CHK(d, 8'h00)
        rd(REG_CFG, d);
        `CHK(d[1:0], 2'h3)
        // Clock-stop: gated copies silenced, free copies keep running
        @(posedge core_clk) stop_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        observe(64);
        `CHK(hi_mg, 0)
        `CHK(hi_cpu, 0)
        `CHK(tog[0] > 0, 1'b1)
        `CHK(tog[5] > 0, 1'b1)
        rd(REG_STATUS, d);
        `CHK(d[ST_GATE_BIT], 1'b0)
        @(posedge core_clk) stop_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        observe(64);
        `CHK(mis_mem, 0)
        `CHK(tog[6] > 0, 1'b1)
        // Mode strap low: shared pin becomes the PCI stop input
        power_up(5'b01001);
        @(posedge core_clk) pci_stop_n <= 1'b0;
        observe(12);
        `CHK(hi_pci > 0, 1'b1)
        repeat (50) @(posedge core_clk);
        observe(64);
        `CHK(hi_pci, 0)
        `CHK(tog[1] > 0, 1'b1)
        rd(REG_STATUS, d);
        `CHK(d[ST_PCI_BIT], 1'b0)
        @(posedge core_clk) pci_stop_n <= 1'b1;
        repeat (50) @(posedge core_clk);
        observe(64);
        `CHK(tog[2] > 0, 1'b1)
        finish_test();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end
endmodule // tb_top
